// [logic/axis_board.sv]
`timescale 1ns/10ps
module axis_board
    import axis_drive_pkg::*;
#(
    parameter int FILTER_CYCLES = FILTER_DELAY_US * 1000 / CLK_PERIOD_NS
) (
    input  wire logic                  core_clk,          // Clock
    input  wire logic                  sys_rst,           // Sync reset
    axis_bus_if.board                  bus,               // Host side
    input  wire logic                  emergencyHalt,     // Halt pin
    input  wire logic [NUM_AXES*2-1:0] overrunLimits,     // +,- per axis
    input  wire logic [NUM_AXES*3-1:0] stopInputs,        // Stop0..2
    output logic      [NUM_AXES-1:0]   pulseOutPositive,  // Drive pulse
    output logic      [NUM_AXES-1:0]   directionOut,      // Dir or - pulse
    output logic      [NUM_AXES-1:0]   holdOffOut,        // Output zero
    output logic      [NUM_AXES*3-1:0] generalOuts        // Outputs 1..3
);
    localparam int NUM_IN = 1 + NUM_AXES * (LIMITS_PER_AXIS + STOPS_PER_AXIS);

    logic                rst;
    logic [NUM_IN-1:0]   rawIns;
    logic [NUM_IN-1:0]   fltIns;
    logic                emgF;
    logic [NUM_AXES*2-1:0] limF;
    logic [NUM_AXES*3-1:0] stopF;
    logic [2:0]          selAxis;
    logic [2:0]          selReg;
    axis_state_t         state    [NUM_AXES];
    logic [15:0]         period   [NUM_AXES];
    logic [15:0]         mode     [NUM_AXES];
    logic [15:0]         outVal   [NUM_AXES];
    logic [15:0]         outEn    [NUM_AXES];
    logic [15:0]         curPeriod[NUM_AXES];
    logic [15:0]         phase    [NUM_AXES];
    logic [6:0]          setupCnt [NUM_AXES];
    logic [3:0]          decelCnt [NUM_AXES];
    logic [NUM_AXES-1:0] dirMinus;
    logic [NUM_AXES-1:0] stopPend;
    logic [NUM_AXES-1:0] decelPend;
    logic [NUM_AXES-1:0] errorFlag;
    logic [NUM_AXES-1:0] intFlag;
    logic [NUM_AXES-1:0] endEvent;
    logic [NUM_AXES-1:0] pulseOn;
    logic [NUM_AXES-1:0] boundary;
    logic [NUM_AXES-1:0] instCause;
    logic [NUM_AXES-1:0] decCause;

    // Board reset from the host acts like the system reset
    assign rst     = sys_rst | ~bus.boardResetN;
    assign selAxis = bus.addr[ADDR_W-1:AXIS_SEL_LSB];
    assign selReg  = bus.addr[AXIS_SEL_LSB-1:0];
    assign rawIns  = {emergencyHalt, overrunLimits, stopInputs};
    assign emgF    = fltIns[NUM_IN-1];
    assign limF    = fltIns[NUM_IN-2 -: NUM_AXES*2];
    assign stopF   = fltIns[NUM_AXES*3-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Sync and integral filtering
    for (genvar g = 0; g < NUM_IN; g++) begin : gFilt
        input_filter #(
            .DELAY_CYCLES(FILTER_CYCLES)
        ) uFilt (
            .core_clk(core_clk),
            .sys_rst (rst),
            .rawIn   (rawIns[g]),
            .filtered(fltIns[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        for (int i = 0; i < NUM_AXES; i++) begin
            logic limHit;
            logic stpHit;
            logic cmdWr;
            limHit = dirMinus[i] ? limF[2*i+1] : limF[2*i];
            stpHit = |(stopF[3*i +: 3] & mode[i][MODE_STOP_EN +: 3]);
            cmdWr  = bus.wrStrobe && selAxis == 3'(i)
                     && selReg == REG_COMMAND;
            instCause[i] = (limHit && !mode[i][MODE_LIMIT_DEC])
                        || (stpHit && !mode[i][MODE_STOP_DEC])
                        || (cmdWr && bus.wrData == CMD_INSTANT_STOP);
            decCause[i] = (limHit && mode[i][MODE_LIMIT_DEC])
                       || (stpHit && mode[i][MODE_STOP_DEC])
                       || (cmdWr && bus.wrData == CMD_DECEL_STOP);
            pulseOn[i]  = (state[i] == AX_RUN || state[i] == AX_DECEL)
                       && phase[i] < (curPeriod[i] >> 1);
            // Pulse edges at the speed now in effect
            boundary[i] = phase[i] == curPeriod[i] - 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive sequencing per axis
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < NUM_AXES; i++) begin
            endEvent[i] <= 1'b0;
            if (rst) begin
                state[i]     <= AX_IDLE;
                dirMinus[i]  <= 1'b0;
                stopPend[i]  <= 1'b0;
                decelPend[i] <= 1'b0;
                errorFlag[i] <= 1'b0;
                phase[i]     <= 16'h0000;
                setupCnt[i]  <= 7'h00;
                decelCnt[i]  <= 4'h0;
                curPeriod[i] <= PERIOD_RESET;
            end else if (emgF) begin
                // Halt every axis at once, flag error
                errorFlag[i] <= 1'b1;
                if (state[i] != AX_IDLE) begin
                    endEvent[i] <= 1'b1;
                end
                state[i] <= AX_IDLE;
            end else begin
                unique case (state[i])
                    AX_IDLE: begin
                        stopPend[i]  <= 1'b0;
                        decelPend[i] <= 1'b0;
                        if (bus.wrStrobe && selAxis == 3'(i)
                            && selReg == REG_COMMAND
                            && (bus.wrData == CMD_DRIVE_POS
                             || bus.wrData == CMD_DRIVE_NEG)) begin
                            // Direction set on the next edge
                            dirMinus[i]  <= bus.wrData == CMD_DRIVE_NEG;
                            errorFlag[i] <= 1'b0;
                            curPeriod[i] <= period[i];
                            phase[i]     <= 16'h0000;
                            setupCnt[i]  <= 7'h00;
                            decelCnt[i]  <= 4'h0;
                            state[i] <= mode[i][MODE_ONE_PULSE]
                                        ? AX_SETUP : AX_RUN;
                        end
                    end
                    AX_SETUP: begin
                        setupCnt[i] <= setupCnt[i] + 7'h01;
                        if (instCause[i]) begin
                            state[i] <= AX_IDLE;
                        end else if (setupCnt[i] == SETUP_LAST) begin
                            state[i] <= AX_RUN;
                        end
                    end
                    AX_RUN, AX_DECEL: begin
                        stopPend[i]  <= stopPend[i] | instCause[i];
                        decelPend[i] <= decelPend[i] | decCause[i];
                        phase[i]     <= boundary[i] ? 16'h0000
                                        : phase[i] + 16'h0001;
                        if (boundary[i]) begin
                            if (stopPend[i] || instCause[i] || (
                                state[i] == AX_DECEL
                                && decelCnt[i] == DECEL_LAST)) begin
                                state[i]    <= AX_IDLE;
                                endEvent[i] <= 1'b1;
                            end else if (state[i] == AX_DECEL) begin
                                decelCnt[i] <= decelCnt[i] + 4'h1;
                                if (curPeriod[i] < PERIOD_MAX) begin
                                    curPeriod[i] <= curPeriod[i]
                                        + (curPeriod[i] >> DECEL_SHIFT);
                                end
                            end else if (decelPend[i] || decCause[i]) begin
                                state[i] <= AX_DECEL;
                            end
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host-written registers
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < NUM_AXES; i++) begin
            if (rst) begin
                period[i] <= PERIOD_RESET;
                mode[i]   <= 16'h0000;
                outVal[i] <= 16'h0000;
                outEn[i]  <= 16'h0000;
            end else if (bus.wrStrobe && selAxis == 3'(i)) begin
                unique case (selReg)
                    REG_PERIOD: period[i] <= (bus.wrData < PERIOD_MIN)
                                             ? PERIOD_MIN : bus.wrData;
                    REG_MODE:   mode[i]   <= bus.wrData;
                    REG_OUTVAL: outVal[i] <= bus.wrData;
                    REG_OUTEN:  outEn[i]  <= bus.wrData;
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt flags; a new end event beats a same-cycle clear
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < NUM_AXES; i++) begin
            if (rst) begin
                intFlag[i] <= 1'b0;
            end else begin
                intFlag[i] <= (endEvent[i] && mode[i][MODE_INT_EN])
                    || (intFlag[i] && !(bus.rdStrobe
                        && selAxis == 3'(i) && selReg == REG_STATUS3));
            end
        end
    end

    // Both controllers share one active-low line
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bus.intaOeN <= 1'b1;
        end else begin
            bus.intaOeN <= ~(|intFlag[AXES_PER_CTRL-1:0]
                           | |intFlag[NUM_AXES-1:AXES_PER_CTRL]);
        end
    end
    assign bus.intaOut = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Read answers one cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bus.rdValid <= 1'b0;
            bus.rdData  <= 16'h0000;
        end else begin
            bus.rdValid <= bus.rdStrobe;
            unique case (selReg)
                REG_COMMAND: bus.rdData <= 16'(
                    {errorFlag[selAxis], state[selAxis] != AX_IDLE});
                REG_PERIOD:  bus.rdData <= period[selAxis];
                REG_MODE:    bus.rdData <= mode[selAxis];
                REG_STATUS3: bus.rdData <= 16'(intFlag[selAxis]);
                REG_OUTVAL:  bus.rdData <= outVal[selAxis];
                REG_OUTEN:   bus.rdData <= outEn[selAxis];
                default:     bus.rdData <= 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs settle one edge into reset
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < NUM_AXES; i++) begin
            if (rst) begin
                pulseOutPositive[i] <= 1'b0;
                directionOut[i]     <= 1'b0;
                holdOffOut[i]       <= 1'b0;
                generalOuts[3*i +: 3] <= 3'h0;
            end else begin
                if (mode[i][MODE_ONE_PULSE]) begin
                    pulseOutPositive[i] <= pulseOn[i];
                    directionOut[i]     <= dirMinus[i];
                end else begin
                    pulseOutPositive[i] <= pulseOn[i] & ~dirMinus[i];
                    directionOut[i]     <= pulseOn[i] & dirMinus[i];
                end
                holdOffOut[i] <= outEn[i][0] & outVal[i][0];
                generalOuts[3*i +: 3] <= outEn[i][3:1] & outVal[i][3:1];
            end
        end
    end
endmodule

// [logic/axis_drive_pkg.sv]
package axis_drive_pkg;
    localparam int CLK_PERIOD_NS    = 5;
    localparam int NUM_AXES         = 8;
    localparam int AXES_PER_CTRL    = 4;
    localparam int DATA_W           = 16;
    localparam int ADDR_W           = 6;
    localparam int AXIS_SEL_LSB     = 3;
    localparam int LIMITS_PER_AXIS  = 2;
    localparam int STOPS_PER_AXIS   = 3;
    localparam int GEN_OUTS_PER_AXIS = 3;

    // Longest times round down, least times round up
    localparam int OUTPUT_SETTLE_NS  = 250;
    localparam int OUTPUT_SETTLE_CYC = OUTPUT_SETTLE_NS / CLK_PERIOD_NS;
    localparam int DRIVE_START_NS    = 650;
    localparam int DRIVE_START_CYC   = DRIVE_START_NS / CLK_PERIOD_NS;
    localparam int DIR_VALID_NS      = 275;
    localparam int DIR_VALID_CYC     = DIR_VALID_NS / CLK_PERIOD_NS;
    localparam int DIR_SETUP_NS      = 375;
    localparam int DIR_SETUP_CYC     =
        (DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOST_GAP_NS       = 500;
    localparam int HOST_GAP_CYC      =
        (HOST_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ENC_GAP_NS        = 200;
    localparam int FILTER_DELAY_US   = 512;

    localparam logic [2:0] REG_COMMAND = 3'h0;
    localparam logic [2:0] REG_PERIOD  = 3'h1;
    localparam logic [2:0] REG_MODE    = 3'h2;
    localparam logic [2:0] REG_STATUS3 = 3'h3;
    localparam logic [2:0] REG_OUTVAL  = 3'h4;
    localparam logic [2:0] REG_OUTEN   = 3'h5;

    localparam logic [15:0] CMD_DRIVE_POS    = 16'h0020;
    localparam logic [15:0] CMD_DRIVE_NEG    = 16'h0021;
    localparam logic [15:0] CMD_DECEL_STOP   = 16'h0026;
    localparam logic [15:0] CMD_INSTANT_STOP = 16'h0027;

    localparam int MODE_ONE_PULSE  = 0;
    localparam int MODE_LIMIT_DEC  = 1;
    localparam int MODE_STOP_EN    = 2;
    localparam int MODE_STOP_DEC   = 5;
    localparam int MODE_INT_EN     = 6;
    localparam int ST_DRIVE        = 0;
    localparam int ST_ERROR        = 1;
    localparam int ST3_END         = 0;

    localparam logic [15:0] PERIOD_RESET = 16'h0064;
    localparam logic [15:0] PERIOD_MIN   = 16'h0004;
    localparam logic [15:0] PERIOD_MAX   = 16'hC000;
    localparam logic [3:0]  DECEL_LAST   = 4'h7;
    localparam int          DECEL_SHIFT  = 2;
    localparam logic [6:0]  SETUP_LAST   = 7'(DIR_SETUP_CYC - 1);

    typedef enum logic [1:0] {
        AX_IDLE  = 2'b00,
        AX_SETUP = 2'b01,
        AX_RUN   = 2'b10,
        AX_DECEL = 2'b11
    } axis_state_t;
endpackage

// [logic/axis_bus_if.sv]
`timescale 1ns/10ps
interface axis_bus_if
    import axis_drive_pkg::*;
(
    input wire logic core_clk   // Shared clock
);
    logic              boardResetN;
    logic              wrStrobe;
    logic              rdStrobe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic [DATA_W-1:0] rdData;
    logic              rdValid;
    logic              intaOut;
    logic              intaOeN;
    wire logic         intaN;

    // Open-drain request line with pull-up
    assign intaN = intaOeN ? 1'b1 : intaOut;

    modport board (
        input  boardResetN, wrStrobe, rdStrobe, addr, wrData,
        output rdData, rdValid, intaOut, intaOeN
    );
    modport host (
        output boardResetN, wrStrobe, rdStrobe, addr, wrData,
        input  rdData, rdValid, intaN
    );
endinterface

// [logic/input_filter.sv]
`timescale 1ns/10ps
module input_filter #(
    parameter int DELAY_CYCLES = 16
) (
    input  wire logic core_clk,  // Clock
    input  wire logic sys_rst,   // Sync reset
    input  wire logic rawIn,     // Pin level, async
    output logic      filtered   // Integrated level
);
    localparam int CNT_W = $clog2(DELAY_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DELAY_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    logic             syncA;
    logic             syncB;
    logic [CNT_W-1:0] level;

    always_ff @(posedge core_clk) begin
        syncA <= rawIn;
        syncB <= syncA;
    end

    // Integrator rejects glitches shorter than the delay
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            level    <= CNT_ZERO;
            filtered <= 1'b0;
        end else begin
            if (syncB && level != CNT_FULL) begin
                level <= level + 1'b1;
            end else if (!syncB && level != CNT_ZERO) begin
                level <= level - 1'b1;
            end
            if (level == CNT_FULL) begin
                filtered <= 1'b1;
            end else if (level == CNT_ZERO) begin
                filtered <= 1'b0;
            end
        end
    end
endmodule

// [logic/axis_host.sv]
`timescale 1ns/10ps
module axis_host
    import axis_drive_pkg::*;
(
    input  wire logic              core_clk,      // Clock
    input  wire logic              sys_rst,       // Sync reset
    axis_bus_if.host               bus,           // Board side
    input  wire logic              resetRequest,  // Pulse board reset
    input  wire logic              cmdValid,      // Request valid
    input  wire logic              cmdWrite,      // 1 write, 0 read
    input  wire logic [ADDR_W-1:0] cmdAddr,       // Register address
    input  wire logic [DATA_W-1:0] cmdData,       // Write data
    output logic                   cmdReady,      // Request accepted
    output logic                   respValid,     // Read data valid
    output logic      [DATA_W-1:0] respData,      // Read data
    output logic                   irqPending     // Board requests service
);
    localparam logic [6:0] GAP_LAST = 7'(HOST_GAP_CYC - 1);

    logic [6:0] gapCnt;
    logic       gapDone;
    logic       readBusy;
    logic       accept;

    assign cmdReady = gapDone & ~readBusy & ~bus.wrStrobe & ~bus.rdStrobe;
    assign accept   = cmdValid & cmdReady;

    ////////////////////////////////////////////////////////////////////////
    // Hold off access for 500 ns after reset release
    always_ff @(posedge core_clk) begin
        if (sys_rst || resetRequest) begin
            bus.boardResetN <= 1'b0;
            gapCnt          <= 7'h00;
            gapDone         <= 1'b0;
        end else begin
            bus.boardResetN <= 1'b1;
            if (bus.boardResetN && !gapDone) begin
                gapCnt  <= gapCnt + 7'h01;
                gapDone <= gapCnt == GAP_LAST;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (sys_rst || resetRequest) begin
            bus.wrStrobe <= 1'b0;
            bus.rdStrobe <= 1'b0;
            bus.addr     <= '0;
            bus.wrData   <= 16'h0000;
            readBusy     <= 1'b0;
            respValid    <= 1'b0;
            respData     <= 16'h0000;
        end else begin
            bus.wrStrobe <= accept & cmdWrite;
            bus.rdStrobe <= accept & ~cmdWrite;
            respValid    <= bus.rdValid;
            if (accept) begin
                bus.addr   <= cmdAddr;
                bus.wrData <= cmdData;
            end
            if (accept && !cmdWrite) begin
                readBusy <= 1'b1;
            end else if (bus.rdValid) begin
                readBusy <= 1'b0;
            end
            if (bus.rdValid) begin
                respData <= bus.rdData;
            end
        end
    end

    // Service ends when the status3 read lands
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irqPending <= 1'b0;
        end else begin
            irqPending <= ~bus.intaN;
        end
    end
endmodule

// [verification/axis_bus_properties.sv]
`timescale 1ns/10ps
module axis_bus_properties
    import axis_drive_pkg::*;
(
    input wire logic              core_clk,    // Clock
    input wire logic              sys_rst,     // Sync reset
    input wire logic              boardResetN, // Board reset
    input wire logic              wrStrobe,    // Write strobe
    input wire logic              rdStrobe,    // Read strobe
    input wire logic [ADDR_W-1:0] addr,        // Address
    input wire logic [DATA_W-1:0] rdData,      // Read data
    input wire logic              rdValid,     // Read valid
    input wire logic              intaOut,     // Driven level
    input wire logic              intaOeN,     // Drive enable
    input wire logic              intaN        // Resolved line
);
    logic [6:0] gap;

    // Saturates: only the first 500 ns matter
    always_ff @(posedge core_clk) begin
        if (sys_rst || !boardResetN) begin
            gap <= 7'h00;
        end else if (gap != 7'h7F) begin
            gap <= gap + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst || !boardResetN);

    rd_answer_a: assert property (rdStrobe |=> rdValid)
        else $error("read not answered next cycle");
    rd_pulse_a: assert property (rdValid |-> $past(rdStrobe) ##1 !rdValid)
        else $error("stray or long read valid");
    strobe_excl_a: assert property (!(wrStrobe && rdStrobe))
        else $error("read and write strobes together");
    rsvd_zero_a: assert property
        (rdStrobe && addr[2:1] == 2'h3 |=> rdData == 16'h0000)
        else $error("reserved register read not zero");
    line_merge_a: assert property (intaN == intaOeN && !intaOut)
        else $error("request line level wrong");
    host_gap_a: assert property
        (wrStrobe || rdStrobe |-> gap >= 7'(HOST_GAP_CYC - 1))
        else $error("access too soon after board reset");
    irq_hold_a: assert property
        (!intaOeN && !$past(rdStrobe) |=> !intaOeN)
        else $error("request released without service");
    irq_clear_a: assert property ($rose(intaOeN) |->
        $past(rdStrobe, 2) && $past(addr[2:0], 2) == REG_STATUS3)
        else $error("request released without status3 read");
endmodule

// [verification/tb.sv]
`timescale 1ns/10ps
module tb
    import axis_drive_pkg::*;
;
    logic                  core_clk = 1'b0;
    logic                  sys_rst = 1'b1;
    logic                  emergencyHalt = 1'b0;
    logic                  rstReq = 1'b0;
    logic [15:0]           lim = 16'h0000;
    logic                  cmdValid = 1'b0;
    logic                  cmdWrite = 1'b0;
    logic [ADDR_W-1:0]     cmdAddr = 6'h00;
    logic [DATA_W-1:0]     cmdData = 16'h0000;
    logic                  cmdReady, respValid, irqPending;
    logic [DATA_W-1:0]     respData, q;
    logic [NUM_AXES-1:0]   pulseOutPositive, directionOut, holdOffOut, prevP;
    logic [NUM_AXES*3-1:0] generalOuts;
    int                    pc [NUM_AXES] = '{default: 0};
    int                    bad_count = 0, n_compared = 0, d, p;

    always #2.5 core_clk = ~core_clk;

    axis_bus_if link (.core_clk(core_clk));
    axis_board #(.FILTER_CYCLES(8)) axis_board_inst (.core_clk(core_clk),
        .sys_rst(sys_rst), .bus(link), .emergencyHalt(emergencyHalt),
        .overrunLimits(lim), .stopInputs(24'h000000),
        .pulseOutPositive(pulseOutPositive), .directionOut(directionOut),
        .holdOffOut(holdOffOut), .generalOuts(generalOuts));
    axis_host axis_host_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .bus(link), .resetRequest(rstReq), .cmdValid(cmdValid),
        .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData),
        .cmdReady(cmdReady), .respValid(respValid), .respData(respData),
        .irqPending(irqPending));
    axis_bus_properties props (.core_clk(core_clk), .sys_rst(sys_rst),
        .boardResetN(link.boardResetN), .wrStrobe(link.wrStrobe),
        .rdStrobe(link.rdStrobe), .addr(link.addr), .rdData(link.rdData),
        .rdValid(link.rdValid), .intaOut(link.intaOut),
        .intaOeN(link.intaOeN), .intaN(link.intaN));

    // Rising edges per axis, the unit of every stop latency
    always @(posedge core_clk) begin
        for (int i = 0; i < NUM_AXES; i++) begin
            if (pulseOutPositive[i] && !prevP[i]) pc[i]++;
        end
        prevP <= pulseOutPositive;
    end

    ////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic xfer(input logic w, input logic [5:0] a,
                        input logic [15:0] dat, output logic [15:0] r);
        int n;
        @(negedge core_clk);
        {cmdValid, cmdWrite, cmdAddr, cmdData} = {1'b1, w, a, dat};
        n = 0;
        #1;
        while (cmdReady !== 1'b1 && n < 300) begin
            cyc(1);
            #1;
            n++;
        end
        if (n >= 300) bad_count++;
        @(negedge core_clk);
        cmdValid = 1'b0;
        n = 0;
        while (!w && respValid !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        if (!w && n >= 20) bad_count++;
        r = respData;
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        #100000;
        bad_count++;
        results();
    end

    initial begin
        cyc(10);
        sys_rst = 1'b0;
        cyc(2);
        chk("pulseRst", {pulseOutPositive, directionOut}, 0);
        chk("genRst", generalOuts, 0);
        chk("earlyReady", cmdReady, 0);
        xfer(1'b1, {3'h0, REG_MODE}, 16'h0041, q);
        xfer(1'b1, {3'h0, REG_PERIOD}, 16'h0010, q);
        xfer(1'b1, {3'h0, REG_COMMAND}, CMD_DRIVE_NEG, q);
        d = 0;
        p = 0;
        for (int i = 1; i < 300 && p == 0; i++) begin
            cyc(1);
            if (d == 0 && directionOut[0]) d = i;
            if (pulseOutPositive[0]) p = i;
        end
        chk("dirTime", d > 0 && d < DIR_VALID_CYC, 1);
        chk("dirSetup", p - d >= DIR_SETUP_CYC, 1);
        chk("startTime", p > 0 && p < DRIVE_START_CYC, 1);
        cyc(40);
        xfer(1'b1, {3'h0, REG_COMMAND}, CMD_INSTANT_STOP, q);
        p = pc[0];
        cyc(60);
        chk("instStop", pc[0] - p <= 1, 1);
        xfer(1'b0, {3'h0, REG_COMMAND}, 16'h0000, q);
        chk("drvBit", q[1:0], 2'h0);
        chk("irqSet", irqPending, 1);
        xfer(1'b0, {3'h0, REG_STATUS3}, 16'h0000, q);
        chk("st3", q[0], 1);
        cyc(4);
        chk("irqClr", link.intaN, 1);
        xfer(1'b1, {3'h4, REG_MODE}, 16'h0040, q);
        xfer(1'b1, {3'h4, REG_PERIOD}, 16'h0008, q);
        xfer(1'b1, {3'h4, REG_COMMAND}, CMD_DRIVE_POS, q);
        cyc(40);
        xfer(1'b1, {3'h4, REG_COMMAND}, CMD_DECEL_STOP, q);
        p = pc[4];
        cyc(400);
        chk("decelCnt", pc[4] - p inside {[7:10]}, 1);
        chk("irqCtl2", irqPending, 1);
        xfer(1'b0, {3'h4, REG_STATUS3}, 16'h0000, q);
        chk("st3Ctl2", q[0], 1);
        cyc(4);
        chk("irqClr2", irqPending, 0);
        xfer(1'b1, {3'h1, REG_COMMAND}, CMD_DRIVE_POS, q);
        xfer(1'b1, {3'h2, REG_COMMAND}, CMD_DRIVE_NEG, q);
        cyc(20);
        emergencyHalt = 1'b1;
        cyc(16);
        p = pc[1];
        cyc(300);
        chk("emgStop", pc[1] - p, 0);
        chk("emgOut", {pulseOutPositive[2:1], directionOut[2:1]}, 0);
        for (int a = 0; a < 4; a++) begin
            xfer(1'b0, {3'(a), REG_COMMAND}, 16'h0000, q);
            chk("emgErr", q[1:0], 2'h2);
        end
        emergencyHalt = 1'b0;
        cyc(20);
        xfer(1'b1, {3'h3, REG_OUTVAL}, 16'h000F, q);
        cyc(2);
        chk("holdGated", {holdOffOut[3], generalOuts[11:9]}, 0);
        xfer(1'b1, {3'h3, REG_OUTEN}, 16'h0001, q);
        cyc(2);
        chk("holdOn", {holdOffOut[3], generalOuts[11:9]}, 4'h8);
        xfer(1'b1, {3'h5, REG_MODE}, 16'h0002, q);
        xfer(1'b1, {3'h5, REG_PERIOD}, 16'h0008, q);
        xfer(1'b1, {3'h5, REG_COMMAND}, CMD_DRIVE_POS, q);
        xfer(1'b1, {3'h6, REG_COMMAND}, CMD_DRIVE_POS, q);
        cyc(20);
        lim = 16'h1400;
        cyc(13);
        p = pc[5];
        d = pc[6];
        cyc(400);
        chk("limDecel", pc[5] - p inside {[7:10]}, 1);
        chk("limStop", pc[6] - d <= 1, 1);
        lim = 16'h0000;
        xfer(1'b1, {3'h3, REG_OUTEN}, 16'h000E, q);
        cyc(2);
        chk("genOn", generalOuts[11:9], 3'h7);
        rstReq = 1'b1;
        cyc(2);
        chk("midRst", {pulseOutPositive, generalOuts}, 0);
        rstReq = 1'b0;
        cyc(2);
        chk("earlyReady2", cmdReady, 0);
        xfer(1'b1, 6'h06, 16'hFFFF, q);
        xfer(1'b0, 6'h06, 16'h0000, q);
        chk("rsvd", q, 16'h0000);
        results();
    end
endmodule
